// ===== rtl/mpiu_top.sv
// Eight-line masked priority interrupt unit on a processor I/O bus.
// Assumes every pin input is asynchronous to ref_clk and held for some clocks.
//
// How it works
// - Set mask bit inhibits that stored line
// - Mask loaded from bus bits zero to seven
// - Mask captured on load strobe; feeds priority
// - Highest unmasked pending line is serviced
// - Clear-all command produces line clear
// - Line clear empties sync register; capture keeps only same-cycle new edges
// - Function ready sets flag; data ready loads, clears
// - Flag records output command to this unit
// - Address enable drives selected line code
// - Completion clears only the serviced line's bit, in both capture and sync registers
// - Inverted irq clock copies capture to sync
// - Request detect sets request memory flag
// - Jump-and-mark input inhibits interrupt activity
// - Priority passed on once own interrupts serviced
// - Request raised only while holding priority
// - System reset clears flags, produces line clear
// - Master enable flag records unit activation
// - Line zero highest, line seven lowest
// - System reset leaves mask unchanged
// - Address is line code above zero bit
`timescale 1ns/1ps
`include "mpiu_params.svh"

module mpiu_top
    import mpiu_pkg::*;
(
    input wire logic ref_clk, // 40 MHz system clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [`MPIU_NLINES-1:0] irq_line_b, // Peripheral lines, low requests
    input wire logic [`MPIU_BUS_W-1:0] bus_bit_in, // I/O bus data in
    input wire logic irq_clock, // Processor interrupt clock
    input wire logic irq_acknowledge, // Processor acknowledge, high active
    input wire logic function_ready_pulse, // Function ready from processor
    input wire logic data_ready_pulse, // Data ready from processor
    input wire logic external_control_strobe, // External control command
    input wire logic device_select, // Decoded device address
    input wire logic system_reset_pulse, // Control-panel system reset
    input wire logic jump_mark_inhibit, // Jump-and-mark inhibit
    input wire logic priority_in, // Priority from chain
    input wire logic service_complete, // Interrupt completion
    output logic irq_request_out_b, // Interrupt request, low active
    output logic priority_out, // Priority to next unit
    output logic [`MPIU_BUS_W-1:0] bus_bit_out, // I/O bus data out
    output logic bus_bit_oe // Bus drive enable
);

    // ======================================================================
    // Input synchroniser
    mpiu_pins_t pins_raw;
    mpiu_pins_t s1_r;
    mpiu_pins_t s2_r;
    mpiu_pins_t prev_r;

    assign pins_raw = '{irq_line_b: irq_line_b, bus_bit_in: bus_bit_in,
        irq_clock: irq_clock, irq_acknowledge: irq_acknowledge,
        function_ready_pulse: function_ready_pulse,
        data_ready_pulse: data_ready_pulse,
        external_control_strobe: external_control_strobe,
        device_select: device_select, system_reset_pulse: system_reset_pulse,
        jump_mark_inhibit: jump_mark_inhibit, priority_in: priority_in,
        service_complete: service_complete};

    // Idle levels avoid false edges right after reset release
    localparam mpiu_pins_t PINS_IDLE = '{irq_line_b: '1, default: '0};

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= PINS_IDLE;
            s2_r <= PINS_IDLE;
            prev_r <= PINS_IDLE;
        end else begin
            s1_r <= pins_raw;
            s2_r <= s1_r;
            prev_r <= s2_r;
        end
    end

    // ======================================================================
    // Edge detection on synchronised pins
    mpiu_lines_t line_fall;
    logic ick_fall;
    logic fry_rise;
    logic dry_rise;
    logic exc_rise;
    logic sys_rise;
    logic svc_rise;
    logic jmp_rise;
    logic [`MPIU_FC_W-1:0] func_code;

    assign line_fall = prev_r.irq_line_b & ~s2_r.irq_line_b;
    // Acknowledge holds the irq clock, so conditions stay static meanwhile
    assign ick_fall = prev_r.irq_clock & ~s2_r.irq_clock & ~s2_r.irq_acknowledge;
    assign fry_rise = s2_r.function_ready_pulse & ~prev_r.function_ready_pulse;
    assign dry_rise = s2_r.data_ready_pulse & ~prev_r.data_ready_pulse;
    assign exc_rise = s2_r.external_control_strobe & ~prev_r.external_control_strobe
        & s2_r.device_select;
    assign sys_rise = s2_r.system_reset_pulse & ~prev_r.system_reset_pulse;
    assign svc_rise = s2_r.service_complete & ~prev_r.service_complete;
    assign jmp_rise = s2_r.jump_mark_inhibit & ~prev_r.jump_mark_inhibit;
    assign func_code = s2_r.bus_bit_in[`MPIU_FC_LSB +: `MPIU_FC_W];

    // ======================================================================
    // External control decode
    logic clear_all_command;
    logic enable_command;
    logic disable_command;
    logic line_clear;

    assign clear_all_command = exc_rise && (func_code == `MPIU_FC_CLEAR);
    assign enable_command = exc_rise && (func_code == `MPIU_FC_ENABLE);
    assign disable_command = exc_rise && (func_code == `MPIU_FC_DISABLE);
    assign line_clear = clear_all_command | sys_rise;

    // ======================================================================
    // Output transfer flag and mask
    logic output_transfer_flag_r;
    logic output_transfer_flag_nxt;
    logic mask_load_strobe;
    logic [`MPIU_MASK_W-1:0] line_inhibit_mask_r;

    // Mask changes only when the program writes it
    assign mask_load_strobe = output_transfer_flag_r & dry_rise;
    assign output_transfer_flag_nxt = sys_rise ? 1'b0 :
        (fry_rise & s2_r.device_select) ? 1'b1 :
        dry_rise ? 1'b0 : output_transfer_flag_r;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            output_transfer_flag_r <= 1'b0;
        end else begin
            output_transfer_flag_r <= output_transfer_flag_nxt;
        end
    end

    // System reset is deliberately absent here; only rst_b gives power-up value
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_inhibit_mask_r <= `MPIU_MASK_RST;
        end else if (mask_load_strobe) begin
            line_inhibit_mask_r <= s2_r.bus_bit_in[`MPIU_MASK_LSB +: `MPIU_MASK_W];
        end
    end

    // ======================================================================
    // Master enable and jump inhibit
    logic master_enable_flag_r;
    logic jump_inhibit_r;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            master_enable_flag_r <= 1'b0;
        end else if (sys_rise | disable_command) begin
            master_enable_flag_r <= 1'b0;
        end else if (enable_command) begin
            master_enable_flag_r <= 1'b1;
        end
    end

    // Inhibit lasts until the next interrupt clock falling edge after the jump
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            jump_inhibit_r <= 1'b0;
        end else if (jmp_rise) begin
            jump_inhibit_r <= 1'b1;
        end else if (ick_fall) begin
            jump_inhibit_r <= 1'b0;
        end
    end

    // ======================================================================
    // Line capture, sync register and priority
    mpiu_lines_t line_capture_bit_r;
    mpiu_lines_t sync_stage_bit_r;
    mpiu_lines_t masked_req;
    mpiu_lines_t line_select;
    mpiu_lines_t svc_clear;
    logic [`MPIU_CODE_W-1:0] line_code_bit;
    logic request_detect;

    assign masked_req = sync_stage_bit_r & ~line_inhibit_mask_r;
    // Lowest index wins: isolate lowest set bit
    assign line_select = masked_req & (~masked_req + 8'h01);
    assign request_detect = |masked_req;
    assign svc_clear = svc_rise ? line_select : 8'h00;

    always_comb begin
        line_code_bit = '0;
        for (int i = `MPIU_NLINES - 1; i >= 0; i--) begin
            if (line_select[i]) begin
                line_code_bit = i[`MPIU_CODE_W-1:0];
            end
        end
    end

    // A new edge beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_capture_bit_r <= `MPIU_LINES_RST;
        end else if (line_clear) begin
            line_capture_bit_r <= line_fall;
        end else begin
            line_capture_bit_r <= (line_capture_bit_r & ~svc_clear) | line_fall;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_stage_bit_r <= `MPIU_LINES_RST;
        end else if (line_clear) begin
            sync_stage_bit_r <= `MPIU_LINES_RST;
        end else if (ick_fall) begin
            sync_stage_bit_r <= line_capture_bit_r & ~svc_clear;
        end else begin
            sync_stage_bit_r <= sync_stage_bit_r & ~svc_clear;
        end
    end

    // ======================================================================
    // Request memory, request, address drive, priority chain
    logic request_memory_flag_r;
    logic active;
    logic address_drive_enable;

    // Set one irq clock period after the line reached the sync register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            request_memory_flag_r <= 1'b0;
        end else if (line_clear) begin
            request_memory_flag_r <= 1'b0;
        end else if (ick_fall) begin
            request_memory_flag_r <= request_detect & master_enable_flag_r;
        end
    end

    assign active = master_enable_flag_r & request_memory_flag_r & ~jump_inhibit_r;
    assign address_drive_enable = active & s2_r.priority_in
        & s2_r.irq_acknowledge & request_detect;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_request_out_b <= 1'b1;
            priority_out <= 1'b0;
            bus_bit_out <= '0;
            bus_bit_oe <= 1'b0;
        end else begin
            irq_request_out_b <= ~(active & s2_r.priority_in);
            // Held while own requests remain, so downstream units wait
            priority_out <= s2_r.priority_in & ~(master_enable_flag_r
                & (request_memory_flag_r | request_detect));
            bus_bit_out <= {{(`MPIU_BUS_W-`MPIU_CODE_W-1){1'b0}},
                line_code_bit, 1'b0};
            bus_bit_oe <= address_drive_enable;
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    mask_load_a: assert property (mask_load_strobe |=>
        line_inhibit_mask_r == $past(s2_r.bus_bit_in[7:0]))
        else $error("mask not loaded from bus");
    mask_hold_a: assert property (!mask_load_strobe |=> $stable(line_inhibit_mask_r))
        else $error("mask changed without strobe");
    mask_block_a: assert property ((line_select & line_inhibit_mask_r) == 8'h00)
        else $error("masked line selected");
    prio_order_a: assert property (line_select != 8'h00 |->
        ((line_select - 8'h01) & masked_req) == 8'h00)
        else $error("lower line beat higher line");
    dto_set_a: assert property (fry_rise && s2_r.device_select && !sys_rise
        |=> output_transfer_flag_r)
        else $error("transfer flag not set");
    dto_clr_a: assert property (output_transfer_flag_r && dry_rise
        && !(fry_rise && s2_r.device_select) |=> !output_transfer_flag_r)
        else $error("transfer flag not cleared");
    sys_clear_a: assert property (sys_rise |=>
        !master_enable_flag_r && !output_transfer_flag_r && sync_stage_bit_r == 8'h00)
        else $error("system reset incomplete");
    clr_all_a: assert property (clear_all_command |=>
        sync_stage_bit_r == 8'h00 && !request_memory_flag_r)
        else $error("line clear incomplete");
    sync_copy_a: assert property (ick_fall && !line_clear && !svc_rise
        |=> sync_stage_bit_r == $past(line_capture_bit_r))
        else $error("sync register not copied");
    req_prio_a: assert property (!irq_request_out_b |->
        $past(s2_r.priority_in) && $past(master_enable_flag_r))
        else $error("request without priority");
    addr_even_a: assert property (bus_bit_oe |-> bus_bit_out[0] == 1'b0
        && $past(s2_r.irq_acknowledge))
        else $error("bad address drive");
    chain_out_a: assert property (priority_out |->
        $past(s2_r.priority_in) && !$past(master_enable_flag_r & request_detect))
        else $error("priority passed early");
    jump_inh_a: assert property (jmp_rise |-> ##2 irq_request_out_b)
        else $error("request during jump inhibit");
    svc_only_a: assert property (svc_rise && !line_clear |=>
        (line_capture_bit_r & ~$past(line_fall | line_select))
        == ($past(line_capture_bit_r) & ~$past(line_fall | line_select))
        && (line_capture_bit_r & $past(line_select & ~line_fall)) == 8'h00)
        else $error("serviced capture bit wrong");

    load_c: cover property (mask_load_strobe ##[1:100] ick_fall);
    req_c: cover property (!irq_request_out_b ##[1:200] bus_bit_oe);
    masked_c: cover property (sync_stage_bit_r[0] && line_inhibit_mask_r[0]
        && line_select[1]);
    svc_c: cover property (svc_rise && line_select != 8'h00);

endmodule

// ===== rtl/mpiu_params.svh
// Constants of the masked priority interrupt unit: widths, codes, reset values.
// Assumes inclusion by bare name from the package and the top module.
`ifndef MPIU_PARAMS_SVH
`define MPIU_PARAMS_SVH

// ==========================================================================
// Widths
`define MPIU_NLINES 8
`define MPIU_BUS_W 16
`define MPIU_CODE_W 3
`define MPIU_MASK_LSB 0
`define MPIU_MASK_W 8

// ==========================================================================
// External control function field on the bus
`define MPIU_FC_LSB 6
`define MPIU_FC_W 3
`define MPIU_FC_CLEAR 3'h0
`define MPIU_FC_ENABLE 3'h1
`define MPIU_FC_DISABLE 3'h2

// ==========================================================================
// Reset values
`define MPIU_MASK_RST 8'h00
`define MPIU_LINES_RST 8'h00

`endif

// ===== rtl/mpiu_pkg.sv
// Types of the masked priority interrupt unit.
// Assumes mpiu_params.svh on the include path.
`include "mpiu_params.svh"

package mpiu_pkg;

    // ======================================================================
    // Pin inputs, carried together through the synchroniser
    typedef struct packed {
        logic [`MPIU_NLINES-1:0] irq_line_b;
        logic [`MPIU_BUS_W-1:0] bus_bit_in;
        logic irq_clock;
        logic irq_acknowledge;
        logic function_ready_pulse;
        logic data_ready_pulse;
        logic external_control_strobe;
        logic device_select;
        logic system_reset_pulse;
        logic jump_mark_inhibit;
        logic priority_in;
        logic service_complete;
    } mpiu_pins_t;

    typedef logic [`MPIU_NLINES-1:0] mpiu_lines_t;

endpackage

// ===== tb/mpiu_proc_model.sv
// Processor side of the interrupt unit: interrupt clock, acknowledge, completion.
// Assumes the bench enables acknowledging and checks the addresses taken.
`timescale 1ns/1ps
`include "mpiu_params.svh"

module mpiu_proc_model (
    input wire logic ref_clk, // System clock
    input wire logic rst_b, // Reset, active low
    input wire logic ack_en, // Bench lets the model answer requests
    input wire logic [7:0] ack_delay, // Clocks before acknowledging
    input wire logic irq_request_out_b, // Request from the unit
    input wire logic bus_bit_oe, // Unit drives the bus
    input wire logic [`MPIU_BUS_W-1:0] bus_bit_out, // Address from the unit
    output logic irq_clock, // Interrupt clock
    output logic irq_acknowledge, // Acknowledge, high active
    output logic service_complete, // Completion after service
    output logic [`MPIU_BUS_W-1:0] got_addr, // Last address taken
    output logic [7:0] got_cnt // Services done
);
    int div;
    int n;

    initial begin
        irq_clock = 1'b0;
        irq_acknowledge = 1'b0;
        service_complete = 1'b0;
        got_addr = 16'h0000;
        got_cnt = 8'h00;
        div = 0;
    end

    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // ======================================================================
    // Interrupt clock, frozen while acknowledged so conditions stay static
    always begin
        step(1);
        if (!rst_b) begin
            div = 0;
        end else if (!irq_acknowledge) begin
            div = div + 1;
            if (div == 8) begin
                div = 0;
                irq_clock = ~irq_clock;
            end
        end
    end

    // ======================================================================
    // Answer a request with acknowledge, take the address, then complete
    always begin
        step(1);
        if (rst_b && ack_en && irq_request_out_b === 1'b0) begin
            step(ack_delay);
            irq_acknowledge = 1'b1;
            n = 0;
            while (bus_bit_oe !== 1'b1 && n < 50) begin
                step(1);
                n = n + 1;
            end
            // A missing drive is reported as an impossible odd address
            got_addr = (bus_bit_oe === 1'b1) ? bus_bit_out : 16'hFFFF;
            service_complete = 1'b1;
            step(6);
            service_complete = 1'b0;
            step(6);
            irq_acknowledge = 1'b0;
            got_cnt = got_cnt + 8'h01;
            // Two and a half interrupt clock periods let the stale request settle
            step(40);
        end
    end
endmodule

// ===== tb/masked_priority_interrupt_unit_test.sv
// Self-checking bench of the interrupt unit against a queue model.
// Assumes the processor model answers requests whenever allowed.
`timescale 1ns/1ps
`include "mpiu_params.svh"

module masked_priority_interrupt_unit_test
    import mpiu_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    mpiu_lines_t irq_line_b = 8'hFF;
    logic [15:0] bus_bit_in = 16'h0000;
    logic fry = 1'b0, dry = 1'b0, exc = 1'b0, dev = 1'b0, sys = 1'b0, prio = 1'b0, jmp = 1'b0;
    logic ack_en = 1'b0;
    logic [7:0] ack_delay = 8'h00;
    logic irq_clock, ack, done, req_b, prio_out, oe;
    logic [15:0] bus_out, got_addr, rnd = 16'h07BC;
    logic [7:0] got_cnt;
    mpiu_lines_t pend = 8'h00, mask_m = 8'h00;
    int miscompares = 0, compares = 0;

    always #12.5 ref_clk = ~ref_clk;

    mpiu_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .irq_line_b(irq_line_b),
        .bus_bit_in(bus_bit_in), .irq_clock(irq_clock), .irq_acknowledge(ack),
        .function_ready_pulse(fry), .data_ready_pulse(dry), .external_control_strobe(exc),
        .device_select(dev), .system_reset_pulse(sys), .jump_mark_inhibit(jmp),
        .priority_in(prio), .service_complete(done), .irq_request_out_b(req_b),
        .priority_out(prio_out), .bus_bit_out(bus_out), .bus_bit_oe(oe));

    mpiu_proc_model proc_u (.ref_clk(ref_clk), .rst_b(rst_b), .ack_en(ack_en),
        .ack_delay(ack_delay), .irq_request_out_b(req_b), .bus_bit_oe(oe),
        .bus_bit_out(bus_out), .irq_clock(irq_clock), .irq_acknowledge(ack),
        .service_complete(done), .got_addr(got_addr), .got_cnt(got_cnt));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic complete_run();
        $display("miscompares %0d compares %0d", miscompares, compares);
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t address got %h exp %h", $time, got, exp);
        end
    endtask

    // ======================================================================
    // Bus operations, spaced past the input synchronisers
    task automatic ext_cmd(input logic [2:0] code);
        bus_bit_in = {7'h00, code, 6'h00};
        dev = 1'b1;
        exc = 1'b1;
        tick(6);
        exc = 1'b0;
        dev = 1'b0;
        tick(6);
    endtask

    task automatic mask_wr(input logic [7:0] m, input logic with_fry);
        dev = 1'b1;
        fry = with_fry;
        tick(6);
        fry = 1'b0;
        bus_bit_in = {8'h00, m};
        dry = 1'b1;
        tick(6);
        dry = 1'b0;
        dev = 1'b0;
        tick(6);
        if (with_fry) mask_m = m;
    endtask

    task automatic raise(input logic [7:0] l);
        irq_line_b = ~l;
        tick(6);
        irq_line_b = 8'hFF;
        pend = pend | l;
        tick(80);
    endtask

    // Serve every unmasked pending line in priority order
    task automatic serve_all();
        int q[$];
        int n;
        logic [7:0] old;
        for (int i = 0; i < 8; i++) if (pend[i] && !mask_m[i]) q.push_back(i);
        rnd = lfsr(rnd);
        ack_delay = {3'h0, rnd[4:0]};
        ack_en = 1'b1;
        while (q.size() > 0) begin
            old = got_cnt;
            n = 0;
            while (got_cnt === old && n < 400) begin
                tick(1);
                n++;
            end
            if (n == 400) begin
                miscompares++;
                complete_run();
            end
            chk_addr(got_addr, 16'(q[0] * 2));
            pend[q.pop_front()] = 1'b0;
        end
        ack_en = 1'b0;
        tick(80);
        chk_bit(req_b, 1'b1);
        chk_bit(prio_out, prio);
    endtask

    initial begin
        tick(5);
        chk_bit(req_b, 1'b1);
        chk_bit(oe, 1'b0);
        rst_b = 1'b1;
        tick(3);
        prio = 1'b1;
        ext_cmd(3'h1);
        for (int r = 0; r < 4; r++) begin
            rnd = lfsr(rnd);
            mask_wr(rnd[7:0], 1'b1);
            rnd = lfsr(rnd);
            raise(rnd[7:0]);
            chk_bit(req_b, (pend & ~mask_m) == 8'h00);
            mask_wr(8'h00, 1'b0);
            serve_all();
            mask_wr(8'h00, 1'b1);
            serve_all();
        end
        raise(8'h0C);
        ext_cmd(3'h0);
        tick(80);
        pend = 8'h00;
        chk_bit(req_b, 1'b1);
        prio = 1'b0;
        raise(8'h10);
        chk_bit(req_b, 1'b1);
        chk_bit(prio_out, 1'b0);
        prio = 1'b1;
        serve_all();
        mask_wr(8'h01, 1'b1);
        sys = 1'b1;
        tick(6);
        sys = 1'b0;
        tick(10);
        raise(8'h03);
        chk_bit(req_b, 1'b1);
        ext_cmd(3'h1);
        tick(80);
        chk_bit(req_b, 1'b0);
        chk_bit(prio_out, 1'b0);
        // Jump inhibit holds at least until the next interrupt clock fall
        jmp = 1'b1;
        tick(4);
        chk_bit(req_b, 1'b1);
        jmp = 1'b0;
        tick(4);
        serve_all();
        mask_wr(8'h00, 1'b1);
        serve_all();
        raise(8'h20);
        ext_cmd(3'h2);
        tick(80);
        chk_bit(req_b, 1'b1);
        ext_cmd(3'h1);
        serve_all();
        complete_run();
    end
endmodule
